/* include/iil_defines.svh */
// Offsets, field positions, codes and timing figures of the interrupt and status logic.
// Assumes bit 0 is the most significant bit of every 16-bit word, as the words are declared [0:15].
`ifndef IIL_DEFINES_SVH
`define IIL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------------------
`define IIL_CW_MC       0
`define IIL_CW_CLRALL   1
`define IIL_CW_SEL_HI   2
`define IIL_CW_SEL_LO   4
`define IIL_CW_TCLR     4
`define IIL_CW_INIT     5
`define IIL_CW_DCTL_HI  6
`define IIL_CW_DCTL_LO  10
`define IIL_CW_DXFER    11
`define IIL_CW_SELDEV   12
`define IIL_CW_BYTE     13
`define IIL_CW_IRQEN    14
`define IIL_CW_TIMER    15

// ----------------------------------------------------------------------------
// Selective clear codes
// ----------------------------------------------------------------------------
`define IIL_CLR_TIMER   3'h1
`define IIL_CLR_IOSYS   3'h2
`define IIL_CLR_CLIF    3'h3
`define IIL_CLR_DXFER   3'h4
`define IIL_CLR_DEV8    3'h5
`define IIL_CLR_DEV9    3'h6
`define IIL_CLR_DEV10   3'h7

// ----------------------------------------------------------------------------
// Interrupt status bit positions
// ----------------------------------------------------------------------------
`define IIL_IRQ_DEV8    8
`define IIL_IRQ_DEV9    9
`define IIL_IRQ_DEV10   10
`define IIL_IRQ_DXFER   11
`define IIL_IRQ_CLIF    12
`define IIL_IRQ_IOSYS   13
`define IIL_IRQ_XERR    14
`define IIL_IRQ_TIMER   15

// ----------------------------------------------------------------------------
// Interface status bit positions
// ----------------------------------------------------------------------------
`define IIL_ST_SIO_OK   0
`define IIL_ST_XFER_OK  1
`define IIL_ST_PEND     2
`define IIL_ST_SEQ_HI   3
`define IIL_ST_SEQ_LO   4
`define IIL_ST_FLAG     5
`define IIL_ST_SEL      6
`define IIL_ST_ZERO     7

// ----------------------------------------------------------------------------
// Direct command codes and timing
// ----------------------------------------------------------------------------
`define IIL_CMD_SIN     3'h7
`define IIL_CMD_RSTINT  3'h3
`define IIL_CMD_SIO     3'h5
`define IIL_CMD_SMSK    3'h1
`define IIL_CMD_CIO     3'h6
`define IIL_CMD_TIO     3'h2
`define IIL_CMD_WIO     3'h4
`define IIL_CMD_RIO     3'h0
`define IIL_TIMEOUT_S   5
`define IIL_CLK_HZ      200000000

`endif

/* include/iil_pkg.sv */
// Types shared by the interrupt and status logic and its two leaf modules.
// Assumes iil_defines.svh is reachable on the include path.
package iil_pkg;
`include "iil_defines.svh"

    typedef enum logic [2:0] {
        cmd_set_interrupt             = `IIL_CMD_SIN,
        cmd_reset_interrupt           = `IIL_CMD_RSTINT,
        start_channel_program_command = `IIL_CMD_SIO,
        cmd_set_mask                  = `IIL_CMD_SMSK,
        cmd_control                   = `IIL_CMD_CIO,
        status_read_command           = `IIL_CMD_TIO,
        direct_write_command          = `IIL_CMD_WIO,
        direct_read_command           = `IIL_CMD_RIO
    } iil_dcmd_t;

    typedef enum logic [1:0] {
        ord_control,
        ord_sense,
        ord_interrupt,
        ord_end
    } iil_order_t;

    typedef struct packed {
        logic        valid;
        iil_dcmd_t   code;
        logic [0:15] data;
    } iil_hcmd_t;

    typedef struct packed {
        logic        valid;
        iil_order_t  order;
        logic [0:15] data;
    } iil_chan_t;

    typedef struct packed {
        logic done;
        logic addr_err;
        logic mem_par;
        logic data_par;
    } iil_xfer_t;

    typedef struct packed {
        logic [8:15] status;
        logic        abort;
        logic        flag;
        logic        pfw;
        logic        pon;
        logic [8:10] strap;
    } iil_pins_t;

    typedef struct packed {
        iil_pins_t s1;
        iil_pins_t s2;
    } iil_sync_st_t;

    typedef struct packed {
        logic bit_r;
    } iil_bit_st_t;

    typedef struct packed {
        logic [0:4] dctl;
        logic       dxfer_en;
        logic       sel_dev;
        logic       byte_mode;
        logic       irq_en;
    } iil_ctrl_t;

    typedef struct packed {
        iil_ctrl_t   ctrl;
        logic        prog_r;
        logic        tmr_run;
        logic [31:0] tmr_cnt;
        logic        ack;
        logic        chan_ack;
        logic [0:15] stat;
        logic [8:10] prev;
        logic        prev_abort;
        logic        mc_out;
        logic        pfw_out;
        logic        pon_out;
        logic        abort_out;
    } iil_state_t;

endpackage

/* verilog/iil_sync.sv */
// Two-stage synchroniser for every pin that enters from the device or backplane.
// Assumes the inputs are asynchronous levels; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none

module iil_sync (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire iil_pkg::iil_pins_t pins_in,
    output iil_pkg::iil_pins_t      pins_out
);

    iil_pkg::iil_sync_st_t s_r;
    iil_pkg::iil_sync_st_t s_nxt;

    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = pins_in;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pins_out = s_r.s2;

endmodule

`default_nettype wire

/* verilog/iil_irq_bit.sv */
// One sticky interrupt status bit.
// Assumes set and clear are single-clock pulses from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module iil_irq_bit (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic clr,
    output logic      bit_out
);

    iil_pkg::iil_bit_st_t s_r;
    iil_pkg::iil_bit_st_t s_nxt;

    // R24 sticky until cleared
    // A set in the clearing cycle wins, so no event is lost.
    always_comb begin
        s_nxt       = s_r;
        s_nxt.bit_r = set | (s_r.bit_r & ~clr);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bit_out = s_r.bit_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_set_wins: assert property (set |=> bit_out) // R24
        else $error("interrupt bit did not set");
    a_bit_holds: assert property (!set && !clr |=> bit_out == $past(bit_out)) // R24
        else $error("interrupt bit changed without cause");

endmodule

`default_nettype wire

/* verilog/iil_core.sv */
// Interrupt request and status word logic of the parallel interface card.
// Assumes host commands, channel orders and transfer events arrive on clk; device pins are asynchronous.
//
// Contract
// R1 - Device lines 8-10 interrupt only when strapped.
// R2 - Strapped lines 8, 9 set on rising edge.
// R3 - Strapped line 10 sets on falling edge.
// R4 - Armed by bit 11, interrupt per transfer.
// R5 - Abort interrupt only during channel program.
// R6 - Device abort ends program, sets abort bit.
// R7 - Set-interrupt command or order sets system bit.
// R8 - Address or parity errors set transfer error.
// R9 - Transfer error blocks transfers until cleared.
// R10 - Bit 15 starts five second timeout timer.
// R11 - Host stops timer with bit 4 high.
// R12 - Status bit 6 high shows device lines.
// R13 - Status bit 6 low shows interrupt byte.
// R14 - Upper status byte always interface status.
// R15 - Latched bit 12 selects byte, shown bit 6.
// R16 - Five control bits latched, driven to device.
// R17 - Master clear, power-fail, power-on to device.
// R18 - Direct commands acknowledged, then performed.
// R19 - After start, channel orders acknowledged, executed.
// R20 - Bits 2-4 select one interrupt to clear; code 1 clears both the timer bit and the transfer error bit.
// R21 - Interrupt bits 11-15 fixed positions.
// R22 - Status bit 2 shows any pending bit.
// R23 - Requests sent only while bit 14 high.
// R24 - Bits stay set until explicitly cleared.
// R25 - Device inputs synchronised before edge detection.
`timescale 1ns/1ps
`default_nettype none
`include "iil_defines.svh"

module iil_core #(
    parameter int unsigned TIMER_CYCLES = `IIL_TIMEOUT_S * `IIL_CLK_HZ
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire iil_pkg::iil_hcmd_t host_cmd,
    output logic                    host_ack,
    output logic [0:15]             host_stat,
    input  wire iil_pkg::iil_chan_t chan_order,
    output logic                    chan_ack,
    output logic                    chan_abort,
    output logic                    prog_active,
    input  wire iil_pkg::iil_xfer_t xfer,
    input  wire logic [1:0]         seq_state,
    input  wire logic               xfer_busy,
    output logic                    xfer_enable,
    output logic                    byte_mode,
    input  wire iil_pkg::iil_pins_t pins,
    output logic [0:4]              dev_ctrl,
    output logic                    dev_master_clear,
    output logic                    dev_power_fail,
    output logic                    dev_power_on,
    output logic                    irq_request
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    localparam logic [31:0] TMR_LAST = 32'(TIMER_CYCLES - 1);

    iil_pkg::iil_state_t s_r;
    iil_pkg::iil_state_t s_nxt;
    iil_pkg::iil_pins_t  sp;

    logic        h_take;
    logic        h_ctl;
    logic        c_take;
    logic        cw_valid;
    logic [0:15] cw;
    logic [0:4]  cw_dctl;
    logic        cw_mc;
    logic        rd_req;
    logic        sio_start;
    logic        abort_rise;
    logic        abort_set;
    logic        expire;
    logic [8:15] irq;
    logic [8:15] irq_set;
    logic [8:15] irq_clr;
    logic        irq_any;
    logic [0:15] stat_word;

    // ------------------------------------------------------------------------
    // Selective clear decode
    // ------------------------------------------------------------------------
    function automatic logic [8:15] clr_mask(input logic [2:0] code);
        logic [8:15] m;
        m = '0;
        unique case (code)
            3'h0: m = '0;
            `IIL_CLR_TIMER: begin
                m[`IIL_IRQ_TIMER] = 1'b1;
                m[`IIL_IRQ_XERR]  = 1'b1;
            end
            `IIL_CLR_IOSYS: m[`IIL_IRQ_IOSYS] = 1'b1;
            `IIL_CLR_CLIF:  m[`IIL_IRQ_CLIF]  = 1'b1;
            `IIL_CLR_DXFER: m[`IIL_IRQ_DXFER] = 1'b1;
            `IIL_CLR_DEV8:  m[`IIL_IRQ_DEV8]  = 1'b1;
            `IIL_CLR_DEV9:  m[`IIL_IRQ_DEV9]  = 1'b1;
            `IIL_CLR_DEV10: m[`IIL_IRQ_DEV10] = 1'b1;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------------
    // R25 two-stage pin sync
    iil_sync u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .pins_in  (pins),
        .pins_out (sp)
    );

    // ------------------------------------------------------------------------
    // Command intake
    // ------------------------------------------------------------------------
    // Channel orders are only honoured while a channel program owns the card.
    assign h_take = host_cmd.valid;
    assign h_ctl  = h_take && (host_cmd.code == iil_pkg::cmd_control);
    assign c_take = chan_order.valid && s_r.prog_r;

    // The host wins when both sides write a control word in one cycle.
    assign cw_valid = h_ctl || (c_take && (chan_order.order == iil_pkg::ord_control));
    assign cw       = h_ctl ? host_cmd.data : chan_order.data;
    assign cw_dctl  = cw[`IIL_CW_DCTL_HI:`IIL_CW_DCTL_LO];
    assign cw_mc    = cw_valid && cw[`IIL_CW_MC];

    assign rd_req = (h_take && (host_cmd.code == iil_pkg::status_read_command))
                  || (c_take && (chan_order.order == iil_pkg::ord_sense));

    // A second start while a program runs is acknowledged and otherwise ignored.
    assign sio_start = h_take && !s_r.prog_r
                     && (host_cmd.code == iil_pkg::start_channel_program_command);

    // ------------------------------------------------------------------------
    // Edge detection and events
    // ------------------------------------------------------------------------
    assign abort_rise = sp.abort && !s_r.prev_abort;
    // R5 abort gated by program
    assign abort_set = abort_rise && s_r.prog_r;
    assign expire = s_r.tmr_run && (s_r.tmr_cnt == TMR_LAST);

    // R21 fixed bit positions
    always_comb begin
        irq_set = '0;
        // R1 strap gates device lines
        // R2 leading edge of 8 and 9
        irq_set[`IIL_IRQ_DEV8]  = sp.strap[8] && sp.status[8] && !s_r.prev[8];
        irq_set[`IIL_IRQ_DEV9]  = sp.strap[9] && sp.status[9] && !s_r.prev[9];
        // R3 trailing edge of 10
        irq_set[`IIL_IRQ_DEV10] = sp.strap[10] && !sp.status[10] && s_r.prev[10];
        // R4 interrupt per transfer
        irq_set[`IIL_IRQ_DXFER] = s_r.ctrl.dxfer_en && xfer.done;
        // R6 abort sets its bit
        irq_set[`IIL_IRQ_CLIF]  = abort_set;
        // R7 set-interrupt sources
        irq_set[`IIL_IRQ_IOSYS] = (h_take && (host_cmd.code == iil_pkg::cmd_set_interrupt))
                                || (c_take && (chan_order.order == iil_pkg::ord_interrupt));
        // R8 transfer error sources
        irq_set[`IIL_IRQ_XERR]  = xfer.addr_err || xfer.mem_par || xfer.data_par;
        // R10 timeout sets its bit
        irq_set[`IIL_IRQ_TIMER] = expire;
    end

    // R20 selective and global clear
    always_comb begin
        irq_clr = '0;
        if (cw_valid) begin
            irq_clr = clr_mask(cw[`IIL_CW_SEL_HI:`IIL_CW_SEL_LO]);
            if (cw[`IIL_CW_MC] || cw[`IIL_CW_CLRALL]) begin
                irq_clr = '1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------------------
    generate
        for (genvar i = 8; i <= 15; i++) begin : g_irq
            // R24 sticky status cell
            iil_irq_bit u_bit (
                .clk     (clk),
                .rst_n   (rst_n),
                .set     (irq_set[i]),
                .clr     (irq_clr[i]),
                .bit_out (irq[i])
            );
        end
    endgenerate

    // R22 pending summary
    assign irq_any = |irq;

    // ------------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------------
    always_comb begin
        stat_word = '0;
        // R14 interface status byte
        stat_word[`IIL_ST_SIO_OK]  = !s_r.prog_r;
        stat_word[`IIL_ST_XFER_OK] = !xfer_busy;
        stat_word[`IIL_ST_PEND]    = irq_any;
        stat_word[`IIL_ST_SEQ_HI]  = seq_state[1];
        stat_word[`IIL_ST_SEQ_LO]  = seq_state[0];
        stat_word[`IIL_ST_FLAG]    = sp.flag;
        // R15 bit 6 shows latched select
        stat_word[`IIL_ST_SEL]     = s_r.ctrl.sel_dev;
        stat_word[`IIL_ST_ZERO]    = 1'b0;
        // R12 device lines when selected
        // R13 interrupt byte otherwise
        stat_word[8:15] = s_r.ctrl.sel_dev ? sp.status : irq;
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_nxt            = s_r;
        s_nxt.ack        = 1'b0;
        s_nxt.chan_ack   = 1'b0;
        s_nxt.abort_out  = 1'b0;
        s_nxt.mc_out     = 1'b0;
        s_nxt.prev       = sp.status[8:10];
        s_nxt.prev_abort = sp.abort;
        // R17 discrete device signals
        s_nxt.pfw_out    = sp.pfw;
        s_nxt.pon_out    = sp.pon;

        // R18 acknowledge direct commands
        if (h_take) begin
            s_nxt.ack = 1'b1;
        end
        // R19 acknowledge channel orders
        if (c_take) begin
            s_nxt.chan_ack = 1'b1;
        end
        if (rd_req) begin
            s_nxt.stat = stat_word;
        end

        // R16 latch control bits
        // R15 latch status select
        if (cw_valid) begin
            s_nxt.ctrl.dctl      = cw_dctl;
            s_nxt.ctrl.dxfer_en  = cw[`IIL_CW_DXFER];
            s_nxt.ctrl.sel_dev   = cw[`IIL_CW_SELDEV];
            s_nxt.ctrl.byte_mode = cw[`IIL_CW_BYTE];
            s_nxt.ctrl.irq_en    = cw[`IIL_CW_IRQEN];
        end

        // R19 program ownership
        if (sio_start) begin
            s_nxt.prog_r = 1'b1;
        end
        if (c_take && (chan_order.order == iil_pkg::ord_end)) begin
            s_nxt.prog_r = 1'b0;
        end
        // R6 abort ends program
        if (abort_set) begin
            s_nxt.prog_r    = 1'b0;
            s_nxt.abort_out = 1'b1;
        end

        // R10 transfer timer
        if (s_r.tmr_run) begin
            s_nxt.tmr_cnt = s_r.tmr_cnt + 32'h1;
        end
        if (expire) begin
            s_nxt.tmr_run = 1'b0;
            s_nxt.tmr_cnt = '0;
        end
        // R11 bit 4 stops timer
        if (cw_valid && cw[`IIL_CW_TCLR]) begin
            s_nxt.tmr_run = 1'b0;
            s_nxt.tmr_cnt = '0;
        end
        // A start in the same word as a stop restarts the count.
        if (cw_valid && cw[`IIL_CW_TIMER]) begin
            s_nxt.tmr_run = 1'b1;
            s_nxt.tmr_cnt = '0;
        end

        // Master clear overrides everything the same word asked for.
        if (cw_mc) begin
            s_nxt.ctrl    = '0;
            s_nxt.prog_r  = 1'b0;
            s_nxt.tmr_run = 1'b0;
            s_nxt.tmr_cnt = '0;
            s_nxt.mc_out  = 1'b1;
        end
    end

    // Master clear to the device is held for the whole reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r        <= '0;
            s_r.mc_out <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign host_ack         = s_r.ack;
    assign host_stat        = s_r.stat;
    assign chan_ack         = s_r.chan_ack;
    assign chan_abort       = s_r.abort_out;
    assign prog_active      = s_r.prog_r;
    assign dev_ctrl         = s_r.ctrl.dctl;
    assign byte_mode        = s_r.ctrl.byte_mode;
    assign dev_master_clear = s_r.mc_out;
    assign dev_power_fail   = s_r.pfw_out;
    assign dev_power_on     = s_r.pon_out;
    // R9 error blocks transfers
    assign xfer_enable      = !irq[`IIL_IRQ_XERR];
    // R23 request gated by bit 14
    assign irq_request      = s_r.ctrl.irq_en && irq_any;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_abort_in_prog;
        s_r.prog_r && abort_rise;
    endsequence

    sequence s_program_gone;
        !prog_active && chan_abort && irq[`IIL_IRQ_CLIF];
    endsequence

    a_direct_ack: assert property (h_take |=> host_ack) // R18
        else $error("direct command not acknowledged");
    a_order_ack: assert property (chan_order.valid && prog_active |=> chan_ack) // R19
        else $error("channel order not acknowledged");
    a_abort_ends: assert property (s_abort_in_prog |=> s_program_gone) // R6
        else $error("abort did not end the program");
    a_abort_idle: assert property (!prog_active && !irq[12] && !irq_clr[12] |=> !irq[12]) // R5
        else $error("abort bit set outside a program");
    a_strap_off: assert property (!sp.strap[8] && !irq[8] && !irq_clr[8] |=> !irq[8]) // R1
        else $error("unstrapped line raised an interrupt");
    a_trail_edge: assert property (sp.strap[10] && s_r.prev[10] && !sp.status[10] |=> irq[10]) // R3
        else $error("trailing edge of line 10 missed");
    a_lead_edge: assert property (sp.strap[9] && !s_r.prev[9] && sp.status[9] |=> irq[9]) // R2
        else $error("leading edge of line 9 missed");
    a_err_block: assert property (!xfer_enable && !irq_clr[`IIL_IRQ_XERR] |=> !xfer_enable) // R9
        else $error("transfer allowed after error");
    a_req_gate: assert property (!s_r.ctrl.irq_en |-> !irq_request) // R23
        else $error("request sent while inhibited");
    a_pend_read: assert property (rd_req |=> host_stat[2] == $past(irq_any)) // R22
        else $error("pending bit wrong in status");
    a_dev_byte: assert property (rd_req && s_r.ctrl.sel_dev |=> host_stat[8:15] == $past(sp.status)) // R12
        else $error("device byte wrong in status");
    a_irq_byte: assert property (rd_req && !s_r.ctrl.sel_dev |=> host_stat[8:15] == $past(irq)) // R13
        else $error("interrupt byte wrong in status");
    a_ctrl_out: assert property (cw_valid && !cw_mc |=> dev_ctrl == $past(cw_dctl)) // R16
        else $error("device control bits not updated");
    a_timeout: assert property (expire && !(cw_valid && cw[`IIL_CW_TIMER]) // R10
        |=> irq[`IIL_IRQ_TIMER] && !s_r.tmr_run)
        else $error("timer expiry not reported");

endmodule

`default_nettype wire

/* test/iil_host_bfm.sv */
// Host processor and channel model issuing direct commands and orders.
// Assumes the card answers each accepted request one clock later.
`timescale 1ns/1ps
`default_nettype none
module iil_host_bfm (
    input  wire logic          clk,
    input  wire logic          host_ack,
    input  wire logic          chan_ack,
    output iil_pkg::iil_hcmd_t host_cmd,
    output iil_pkg::iil_chan_t chan_order
);
    initial begin
        host_cmd = '0;
        chan_order = '0;
    end
    task automatic dcmd(input iil_pkg::iil_dcmd_t c, input logic [0:15] d, output logic a);
        @(negedge clk);
        host_cmd = {1'b1, c, d};
        @(negedge clk);
        host_cmd = '0;
        a = host_ack;
    endtask
    task automatic ord(input iil_pkg::iil_order_t o, output logic a);
        @(negedge clk);
        chan_order = {1'b1, o, 16'h0000};
        @(negedge clk);
        chan_order = '0;
        a = chan_ack;
    endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Testbench for the interrupt and status logic.
// Assumes the timer is shortened to 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    iil_pkg::iil_hcmd_t hc;
    iil_pkg::iil_chan_t co;
    iil_pkg::iil_xfer_t xf = '0;
    iil_pkg::iil_pins_t pn = '0;
    logic               ack, cack, pa, xen, mc, irq, a;
    logic               ab, pf, po, bm;
    logic               xb = 1'b0;
    logic               abs = 1'b0;
    logic [1:0]         sq = 2'h0;
    logic [0:15]        st;
    logic [0:4]         dc;
    int                 fails = 0;
    int                 checked = 0;
    int                 cyc = 0;
    always #2.5 clk = ~clk;
    iil_host_bfm u_host (.clk(clk), .host_ack(ack), .chan_ack(cack), .host_cmd(hc), .chan_order(co));
    iil_core #(.TIMER_CYCLES(20)) u_iil_core (
        .clk(clk), .rst_n(rst_n), .host_cmd(hc), .host_ack(ack), .host_stat(st),
        .chan_order(co), .chan_ack(cack), .chan_abort(ab), .prog_active(pa), .xfer(xf),
        .seq_state(sq), .xfer_busy(xb), .xfer_enable(xen), .byte_mode(bm), .pins(pn),
        .dev_ctrl(dc), .dev_master_clear(mc), .dev_power_fail(pf), .dev_power_on(po),
        .irq_request(irq));
    // The abort pulse stands one cycle only, so it is caught here and kept.
    always @(posedge clk) abs <= abs | ab;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [0:15] d);
        u_host.dcmd(iil_pkg::cmd_control, d, a);
        chk(a, 1);
    endtask
    task automatic rd();
        u_host.dcmd(iil_pkg::status_read_command, 16'h0000, a);
        chk(a, 1);
    endtask
    task automatic pulse(input logic [3:0] v);
        xf = v;
        @(negedge clk);
        xf = '0;
        @(negedge clk);
    endtask
    // The ceiling is about eighteen times the length of the whole sequence.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        chk(mc, 1);
        rst_n = 1'b1;
        wr(16'h02a2);
        chk(dc, 5'h15);
        u_host.dcmd(iil_pkg::cmd_set_interrupt, 16'h0000, a);
        rd();
        chk({st[2], st[13], irq}, 3'h7);
        wr(16'h1002);
        rd();
        chk({st[2], st[13]}, 2'h0);
        wr(16'h0003);
        repeat (25) @(negedge clk);
        rd();
        chk(st[15], 1);
        wr(16'h0803);
        repeat (10) @(negedge clk);
        wr(16'h0802);
        repeat (25) @(negedge clk);
        rd();
        chk(st[15], 0);
        for (int k = 0; k < 3; k++) begin
            pulse(4'h4 >> k);
            chk(xen, 0);
            wr(16'h0802);
            chk(xen, 1);
        end
        wr(16'h0012);
        pulse(4'h8);
        rd();
        chk(st[11], 1);
        wr(16'h000c);
        pn.status = 8'ha5;
        pn.abort = 1'b1;
        {pn.flag, pn.pfw, pn.pon, xb, sq} = 6'h3e;
        repeat (4) @(negedge clk);
        rd();
        chk({st[6], st[8:15]}, 9'h1a5);
        chk({st[0:7], irq}, 9'h16c);
        chk({pf, po}, 2'h3);
        chk({st[6], bm}, 2'h3);
        pn.abort = 1'b0;
        pn.strap = 3'h7;
        wr(16'h0000);
        rd();
        chk({st[6], st[8:10], st[12]}, 5'h0);
        pn.status = 8'h40;
        repeat (4) @(negedge clk);
        rd();
        chk(st[8:10], 3'h3);
        wr(16'h3000);
        rd();
        chk(st[8:11], 4'h3);
        wr(16'h2000);
        rd();
        chk(st[8:11], 4'h2);
        wr(16'h4000);
        rd();
        chk(st[2], 0);
        u_host.dcmd(iil_pkg::start_channel_program_command, 16'h0000, a);
        chk(pa, 1);
        u_host.ord(iil_pkg::ord_control, a);
        chk(a, 1);
        u_host.ord(iil_pkg::ord_interrupt, a);
        pn.abort = 1'b1;
        repeat (4) @(negedge clk);
        rd();
        chk({pa, st[12], abs}, 3'h3);
        chk(st[13], 1);
        wr(16'h1800);
        rd();
        chk(st[12:13], 2'h1);
        u_host.dcmd(iil_pkg::start_channel_program_command, 16'h0000, a);
        u_host.ord(iil_pkg::ord_end, a);
        chk(pa, 0);
        u_host.ord(iil_pkg::ord_sense, a);
        chk(a, 0);
        close_out();
    end
endmodule
`default_nettype wire
